/* pkg/rpm_pkg.sv */
package rpm_pkg;
   localparam int unsigned CLK_HZ = 200000000;
   localparam int unsigned DWELL_S = 30;
   localparam int unsigned RTC_PERIOD_S = 300;
   localparam longint unsigned DWELL_CYCLES = longint'(DWELL_S) * CLK_HZ;
   localparam longint unsigned RTC_CYCLES = longint'(RTC_PERIOD_S) * CLK_HZ;
   localparam int GRANT_W = 8;
   localparam int CNT_W = 40;
   // register map
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_WAKE_SEL = 4'h1;
   localparam logic [3:0] ADDR_GRANT = 4'h2;
   localparam logic [3:0] ADDR_ARM = 4'h3;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_WAKE_FLAG = 4'h5;
   localparam logic [3:0] ADDR_APP_TIMER = 4'h6;
   localparam logic [3:0] ADDR_SSW = 4'h7;
   // ctrl bits
   localparam int CTRL_PM_EN = 0;
   localparam int CTRL_SSW_APP = 1;
   localparam int CTRL_AO_SET = 2;
   localparam int CTRL_TASKS_IDLE = 3;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // wake source bit positions
   localparam int NWAKE = 9;
   localparam int WK_DI_A = 0;
   localparam int WK_DI_B = 1;
   localparam int WK_DI_C = 2;
   localparam int WK_BUTTON = 3;
   localparam int WK_PORT1 = 4;
   localparam int WK_PORT2 = 5;
   localparam int WK_RADIO = 6;
   localparam int WK_RTC = 7;
   localparam int WK_APP = 8;
   localparam logic [8:0] WAKE_SEL_RESET = 9'h000;
   // grant register commands
   localparam int GRANT_TAKE = 0;
   localparam int GRANT_GIVE = 1;
   // supply output bits
   localparam int SUP_RADIO = 0;
   localparam int SUP_AI = 1;
   localparam int SUP_AO = 2;
   localparam int SUP_SSW = 3;
   localparam int SUP_PERIPH = 4;
   localparam int SUP_PORT1 = 5;
   localparam int SUP_PORT2 = 6;
   localparam logic [6:0] SUP_ALL_ON = 7'h7F;
   typedef enum logic [2:0] {
      RPM_RUN = 3'b001,
      RPM_IDLE = 3'b010,
      RPM_LOW = 3'b100
   } rpm_state_t;
endpackage

/* hw/rpm_power_mode_controller.sv */
`timescale 1ns/100ps
module rpm_power_mode_controller
   import rpm_pkg::*;
#(
   parameter longint unsigned DWELL_COUNT = rpm_pkg::DWELL_CYCLES,
   parameter longint unsigned RTC_COUNT = rpm_pkg::RTC_CYCLES
)
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic wake_digital_input_a,
   input wire logic wake_digital_input_b,
   input wire logic wake_digital_input_c,
   input wire logic push_button,
   input wire logic port1_rx_activity,
   input wire logic port2_rx_activity,
   input wire logic radio_channel_active,
   input wire logic supply_below_low,
   input wire logic supply_above_high,
   output logic supply_radio_en,
   output logic supply_ai_en,
   output logic supply_ao_en,
   output logic supply_ssw_en,
   output logic supply_periph_en,
   output logic supply_port1_en,
   output logic supply_port2_en,
   output logic solid_state_switch_a,
   output logic solid_state_switch_b,
   output logic [1:0] power_state,
   output logic wake_irq_pulse
);
   import rpm_pkg::*;

   localparam int NPIN = 9;
   rpm_state_t state;
   rpm_state_t next_state;
   rpm_state_t saved_state;
   logic [31:0] ctrl;
   logic [8:0] wake_sel;
   logic [8:0] wake_arm;
   logic [8:0] wake_flag;
   logic [GRANT_W-1:0] grant_cnt;
   logic [CNT_W-1:0] dwell_cnt;
   logic [CNT_W-1:0] rtc_cnt;
   logic [31:0] app_timer;
   logic [1:0] ssw_app;
   logic [NPIN-1:0] pin_meta;
   logic [NPIN-1:0] pin_sync;
   logic [NPIN-1:0] pin_last;
   logic [8:0] wake_raw;
   logic [8:0] wake_hit;
   logic rtc_tick;
   logic app_tick;
   logic idle_ok;
   logic low_supply;
   logic high_supply;
   logic [8:0] wake_need;
   logic [1:0] sync_fill;
   logic edges_ok;

   function automatic logic sel(input logic [3:0] a, input logic [3:0] b);
      sel = (a == b);
   endfunction

   // two-bit mode code on the pins: 0 run, 1 idle sleep, 2 low power sleep
   function automatic logic [1:0] mode_code(input rpm_state_t s);
      case (s)
         RPM_IDLE: mode_code = 2'h1;
         RPM_LOW: mode_code = 2'h2;
         default: mode_code = 2'h0;
      endcase
   endfunction

   // two-flop synchronisers for all pins, edge detection compares the second stage with a third, pin_last
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pin_meta <= '0;
         pin_sync <= '0;
         pin_last <= '0;
      end
      else
      begin
         pin_meta <= {supply_above_high, supply_below_low, radio_channel_active,
                      port2_rx_activity, port1_rx_activity, push_button,
                      wake_digital_input_c, wake_digital_input_b, wake_digital_input_a};
         pin_sync <= pin_meta;
         pin_last <= pin_sync;
      end
   end

   // edges count only once the chain holds real pin levels; a pin resting
   // high through reset would otherwise pass for a fresh event
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         sync_fill <= 2'h0;
      else if (sync_fill != 2'h3)
         sync_fill <= sync_fill + 2'h1;
   end

   assign edges_ok = (sync_fill == 2'h3);
   assign low_supply = pin_sync[7];
   assign high_supply = pin_sync[8];
   // sources picked by software or armed by a task both count as selected
   assign wake_need = wake_sel | wake_arm;
   assign rtc_tick = (rtc_cnt == CNT_W'(RTC_COUNT - 1));
   assign app_tick = (app_timer == 32'h0000_0001);

   always_comb
   begin
      wake_raw = '0;
      for (int i = 0; i < 3; i++)
      begin
         wake_raw[i] = pin_sync[i] ^ pin_last[i];
      end
      wake_raw[WK_BUTTON] = pin_sync[3] & ~pin_last[3];
      wake_raw[WK_PORT1] = pin_sync[4] & ~pin_last[4];
      wake_raw[WK_PORT2] = pin_sync[5] & ~pin_last[5];
      wake_raw[WK_RADIO] = pin_sync[6] & ~pin_last[6];
      wake_raw[WK_RTC] = rtc_tick;
      wake_raw[WK_APP] = app_tick;
      if (!edges_ok)
      begin
         wake_raw[WK_RADIO:WK_DI_A] = 7'h00;
      end
      // button and rtc tick always count, others need selection or arming
      wake_hit = wake_raw & wake_need;
      wake_hit[WK_BUTTON] = wake_raw[WK_BUTTON];
      wake_hit[WK_RTC] = wake_raw[WK_RTC];
   end

   // software tells us tasks are idle; grant count must also be zero
   assign idle_ok = ctrl[CTRL_PM_EN] & ctrl[CTRL_TASKS_IDLE]
                    & (grant_cnt == '0)
                    & ~|(wake_raw & wake_arm)
                    & (dwell_cnt == '0)
                    & ~|wake_flag;

   always_comb
   begin
      next_state = state;
      case (state)
         RPM_RUN:
         begin
            if (low_supply)
               next_state = RPM_LOW;
            else if (idle_ok)
               next_state = RPM_IDLE;
         end
         RPM_IDLE:
         begin
            if (low_supply)
               next_state = RPM_LOW;
            else if (|wake_hit)
               next_state = RPM_RUN;
         end
         RPM_LOW:
         begin
            if (high_supply && !low_supply)
               next_state = saved_state;
         end
         // an illegal code falls back to run, the safe mode
         default:
            next_state = RPM_RUN;
      endcase
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state <= RPM_RUN;
         saved_state <= RPM_RUN;
      end
      else
      begin
         state <= next_state;
         // remember where low supply struck so recovery returns there
         if (state != RPM_LOW && next_state == RPM_LOW)
            saved_state <= state;
      end
   end

   // dwell after button wake, free-running rtc tick
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         dwell_cnt <= '0;
         rtc_cnt <= '0;
      end
      else
      begin
         rtc_cnt <= rtc_tick ? '0 : rtc_cnt + CNT_W'(1);
         if (state == RPM_IDLE && wake_raw[WK_BUTTON])
            dwell_cnt <= CNT_W'(DWELL_COUNT);
         else if (dwell_cnt != '0)
            dwell_cnt <= dwell_cnt - CNT_W'(1);
      end
   end

   // register writes
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctrl <= CTRL_RESET;
         wake_sel <= WAKE_SEL_RESET;
         wake_arm <= '0;
         app_timer <= '0;
         ssw_app <= '0;
      end
      else
      begin
         if (reg_wr && sel(reg_addr, ADDR_CTRL))
            ctrl <= reg_wdata;
         if (reg_wr && sel(reg_addr, ADDR_WAKE_SEL))
            wake_sel <= reg_wdata[8:0];
         if (reg_wr && sel(reg_addr, ADDR_ARM))
            wake_arm <= reg_wdata[8:0];
         if (reg_wr && sel(reg_addr, ADDR_SSW))
            ssw_app <= reg_wdata[1:0];
         // a fresh load wins over the countdown in progress
         if (reg_wr && sel(reg_addr, ADDR_APP_TIMER))
            app_timer <= reg_wdata;
         else if (app_timer != '0)
            app_timer <= app_timer - 32'h0000_0001;
      end
   end

   // grant counter: take and give may both come in one write
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         grant_cnt <= '0;
      else if (reg_wr && sel(reg_addr, ADDR_GRANT))
      begin
         if (reg_wdata[GRANT_TAKE] && !reg_wdata[GRANT_GIVE] && grant_cnt != '1)
            grant_cnt <= grant_cnt + GRANT_W'(1);
         else if (reg_wdata[GRANT_GIVE] && !reg_wdata[GRANT_TAKE] && grant_cnt != '0)
            grant_cnt <= grant_cnt - GRANT_W'(1);
      end
   end

   // per-source task flags; set wins over write-one-to-clear
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wake_flag <= '0;
         wake_irq_pulse <= 1'b0;
      end
      else
      begin
         // low power sleep drops all events
         if (state == RPM_LOW)
         begin
            wake_flag <= wake_flag & ~((reg_wr && sel(reg_addr, ADDR_WAKE_FLAG)) ?
                         reg_wdata[8:0] : 9'h000);
            wake_irq_pulse <= 1'b0;
         end
         else
         begin
            // independent of enable bit
            wake_flag <= (wake_flag & ~((reg_wr && sel(reg_addr, ADDR_WAKE_FLAG)) ?
                         reg_wdata[8:0] : 9'h000)) | (wake_raw & wake_arm);
            wake_irq_pulse <= |(wake_raw & wake_arm);
         end
      end
   end

   // supplies and switches, all registered
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         {supply_port2_en, supply_port1_en, supply_periph_en, supply_ssw_en,
          supply_ao_en, supply_ai_en, supply_radio_en} <= SUP_ALL_ON;
         solid_state_switch_a <= 1'b0;
         solid_state_switch_b <= 1'b0;
         power_state <= 2'h0;
      end
      else
      begin
         power_state <= mode_code(next_state);
         if (next_state == RPM_RUN)
         begin
            // run trades current for every port being ready at once
            {supply_port2_en, supply_port1_en, supply_periph_en, supply_ssw_en,
             supply_ao_en, supply_ai_en, supply_radio_en} <= SUP_ALL_ON;
         end
         else
         begin
            // rail kept for any source needing peripherals; low mode keeps nothing
            supply_radio_en <= (next_state == RPM_IDLE) && wake_need[WK_RADIO];
            supply_ai_en <= 1'b0;
            supply_ao_en <= (next_state == RPM_IDLE) && ctrl[CTRL_AO_SET];
            supply_ssw_en <= 1'b0;
            supply_periph_en <= (next_state == RPM_IDLE) && |wake_need[2:0];
            supply_port1_en <= (next_state == RPM_IDLE) && wake_need[WK_PORT1];
            supply_port2_en <= (next_state == RPM_IDLE) && wake_need[WK_PORT2];
         end
         if (next_state == RPM_LOW)
         begin
            solid_state_switch_a <= 1'b0;
            solid_state_switch_b <= 1'b0;
         end
         else if (ctrl[CTRL_SSW_APP])
         begin
            solid_state_switch_a <= ssw_app[0];
            solid_state_switch_b <= ssw_app[1];
         end
         else
         begin
            solid_state_switch_a <= (next_state == RPM_RUN);
            solid_state_switch_b <= (next_state == RPM_RUN);
         end
      end
   end

   // read port, data one cycle after strobe; unmapped reads zero
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         reg_rdata <= '0;
      else if (reg_rd)
      begin
         case (reg_addr)
            ADDR_CTRL: reg_rdata <= ctrl;
            ADDR_WAKE_SEL: reg_rdata <= {23'h0, wake_sel};
            ADDR_GRANT: reg_rdata <= {24'h0, grant_cnt};
            ADDR_ARM: reg_rdata <= {23'h0, wake_arm};
            ADDR_STATUS: reg_rdata <= {27'h0, (dwell_cnt != '0), state, low_supply};
            ADDR_WAKE_FLAG: reg_rdata <= {23'h0, wake_flag};
            ADDR_APP_TIMER: reg_rdata <= app_timer;
            ADDR_SSW: reg_rdata <= {30'h0, ssw_app};
            default: reg_rdata <= 32'h0000_0000;
         endcase
      end
      else
         reg_rdata <= '0;
   end
endmodule

/* dv/rpm_supply_model.sv */
`timescale 1ns/100ps
// input power monitor: two comparator flags, both low inside the band
module rpm_supply_model
(
   input wire logic [15:0] supply_mv,
   output logic supply_below_low,
   output logic supply_above_high
);
   assign supply_below_low = supply_mv < 16'h22C4;
   assign supply_above_high = supply_mv >= 16'h2454;
endmodule

/* dv/rpm_power_mode_monitor.sv */
`timescale 1ns/100ps
module rpm_power_mode_monitor
   import rpm_pkg::*;
#(
   parameter longint unsigned DWELL_COUNT = rpm_pkg::DWELL_CYCLES,
   parameter longint unsigned RTC_COUNT = rpm_pkg::RTC_CYCLES
)
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic push_button,
   input wire logic supply_below_low,
   input wire logic supply_above_high,
   input wire logic supply_radio_en,
   input wire logic supply_ai_en,
   input wire logic solid_state_switch_a,
   input wire logic solid_state_switch_b,
   input wire logic [1:0] power_state,
   input wire logic wake_irq_pulse
);
   import rpm_pkg::*;
   logic [2:0] quiet;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);
   // upper flag absent long enough to clear the synchroniser
   always_ff @(posedge core_clk or negedge reset_n)
      if (!reset_n)
         quiet <= 3'h0;
      else if (supply_above_high)
         quiet <= 3'h0;
      else if (quiet != 3'h7)
         quiet <= quiet + 3'h1;
   a_reset_run: assert property ($rose(reset_n) |-> power_state == 2'h0)
      else $error("not in run after reset");
   a_run_supplies_on: assert property (power_state == 2'h0 && $past(power_state) == 2'h0
      && $past(power_state, 2) == 2'h0 |-> supply_radio_en && supply_ai_en)
      else $error("supply off in run");
   a_idle_ai_off: assert property (power_state == 2'h1 && $past(power_state) == 2'h1
      |-> !supply_ai_en)
      else $error("analog input supply on in idle");
   a_low_entry: assert property ($rose(supply_below_low) |-> ##[1:6] power_state == 2'h2)
      else $error("low supply not entered");
   a_low_holds: assert property (power_state == 2'h2 && quiet == 3'h7 |=> power_state == 2'h2)
      else $error("left low supply too early");
   a_low_exit: assert property ((supply_above_high && !supply_below_low)[*3]
      ##0 power_state == 2'h2 |-> ##[0:3] power_state != 2'h2)
      else $error("low supply not left");
   a_low_switch_off: assert property (power_state == 2'h2 && $past(power_state) == 2'h2
      |-> !solid_state_switch_a && !solid_state_switch_b)
      else $error("switch on in low supply");
   a_low_no_wake: assert property (power_state == 2'h2 && $past(power_state) == 2'h2
      && $past(power_state, 2) == 2'h2 |-> !wake_irq_pulse)
      else $error("wake signalled in low supply");
   a_button_wake: assert property (power_state == 2'h1 && $rose(push_button)
      |-> ##[1:6] power_state == 2'h0)
      else $error("button did not wake");
endmodule
bind rpm_power_mode_controller rpm_power_mode_monitor #(
   .DWELL_COUNT(DWELL_COUNT), .RTC_COUNT(RTC_COUNT)) i_rpm_power_mode_monitor (
   .core_clk(core_clk), .reset_n(reset_n), .push_button(push_button),
   .supply_below_low(supply_below_low), .supply_above_high(supply_above_high),
   .supply_radio_en(supply_radio_en), .supply_ai_en(supply_ai_en),
   .solid_state_switch_a(solid_state_switch_a), .solid_state_switch_b(solid_state_switch_b),
   .power_state(power_state), .wake_irq_pulse(wake_irq_pulse));

/* dv/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
   import rpm_pkg::*;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [2:0] di = 3'h0;
   logic button = 1'b0;
   logic [2:0] rx = 3'h0;
   logic [15:0] mv = 16'h2EE0;
   logic below;
   logic above;
   logic [6:0] sup;
   logic [1:0] sw;
   logic [1:0] power_state;
   logic wake_irq_pulse;
   int n_errors = 0;
   int compares = 0;
   int cycles = 0;
   int pulses = 0;
   int p0;
   int k;
   always #2.5 core_clk = ~core_clk;
   // short counts keep dwell and periodic wake inside the run
   rpm_power_mode_controller #(.DWELL_COUNT(100), .RTC_COUNT(500)) i_rpm_power_mode_controller (
      .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .wake_digital_input_a(di[0]), .wake_digital_input_b(di[1]),
      .wake_digital_input_c(di[2]), .push_button(button), .port1_rx_activity(rx[0]),
      .port2_rx_activity(rx[1]), .radio_channel_active(rx[2]),
      .supply_below_low(below), .supply_above_high(above),
      .supply_radio_en(sup[SUP_RADIO]), .supply_ai_en(sup[SUP_AI]), .supply_ao_en(sup[SUP_AO]),
      .supply_ssw_en(sup[SUP_SSW]), .supply_periph_en(sup[SUP_PERIPH]),
      .supply_port1_en(sup[SUP_PORT1]), .supply_port2_en(sup[SUP_PORT2]),
      .solid_state_switch_a(sw[0]), .solid_state_switch_b(sw[1]),
      .power_state(power_state), .wake_irq_pulse(wake_irq_pulse));
   rpm_supply_model i_rpm_supply_model (
      .supply_mv(mv), .supply_below_low(below), .supply_above_high(above));
   task automatic summarize();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk("read data", exp, reg_rdata);
      @(posedge core_clk);
   endtask
   // sampled on the falling edge, away from register updates
   task automatic wait_st(input logic [1:0] s, input int lim, input string what);
      int i = 0;
      do
      begin
         @(negedge core_clk);
         i++;
      end
      while (power_state !== s && i < lim);
      chk(what, {30'h0, s}, {30'h0, power_state});
      @(posedge core_clk);
   endtask
   task automatic hold_st(input logic [1:0] s, input int n, input string what);
      logic ok = 1'b1;
      repeat (n)
      begin
         @(negedge core_clk);
         ok &= (power_state === s);
      end
      chk(what, 32'h1, {31'h0, ok});
      @(posedge core_clk);
   endtask
   task automatic pin(input int n);
      if (n < 3)
         di[n] <= ~di[n];
      else
         rx[n - 3] <= 1'b1;
   endtask
   // pulses counted mid-cycle, clear of the edge that launches them
   always @(negedge core_clk)
   begin
      if (wake_irq_pulse === 1'b1)
         pulses++;
   end
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         n_errors++;
         summarize();
      end
   end
   initial
   begin
      repeat (16) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      chk("state", 32'h0, {30'h0, power_state});
      chk("supplies", 32'h7F, {25'h0, sup});
      rd(ADDR_CTRL, CTRL_RESET);
      rd(ADDR_WAKE_SEL, 32'h0);
      rd(4'hF, 32'h0);
      chk("run switches", 32'h3, {30'h0, sw});
      $display("reset test done");
      wr(ADDR_GRANT, 32'h1);
      wr(ADDR_GRANT, 32'h1);
      rd(ADDR_GRANT, 32'h2);
      wr(ADDR_WAKE_SEL, 32'h1);
      wr(ADDR_CTRL, 32'h9);
      wr(ADDR_GRANT, 32'h2);
      hold_st(2'h0, 30, "grant held");
      wr(ADDR_GRANT, 32'h2);
      wait_st(2'h1, 20, "idle entry");
      repeat (3) @(posedge core_clk);
      chk("idle supplies", 32'h10, {25'h0, sup});
      chk("idle switches", 32'h0, {30'h0, sw});
      $display("grant test done");
      for (k = 0; k < 6; k++)
      begin
         wr(ADDR_WAKE_SEL, 32'h0);
         wait_st(2'h1, 20, "idle");
         pin(k);
         hold_st(2'h1, 12, "unselected source");
         rx <= 3'h0;
         wr(ADDR_WAKE_SEL, 32'h1 << (k < 3 ? k : k + 1));
         pin(k);
         wait_st(2'h0, 12, "selected wake");
         rx <= 3'h0;
      end
      $display("source test done");
      wr(ADDR_WAKE_SEL, 32'h0);
      wait_st(2'h1, 20, "idle");
      wait_st(2'h0, 600, "periodic wake");
      wr(ADDR_WAKE_SEL, 32'h100);
      wait_st(2'h1, 20, "idle");
      wr(ADDR_APP_TIMER, 32'h28);
      hold_st(2'h1, 30, "timer running");
      wait_st(2'h0, 20, "timer wake");
      wait_st(2'h1, 20, "idle");
      button <= 1'b1;
      wait_st(2'h0, 10, "button wake");
      button <= 1'b0;
      hold_st(2'h0, 80, "dwell");
      wait_st(2'h1, 40, "dwell end");
      $display("timer test done");
      wr(ADDR_SSW, 32'h3);
      wr(ADDR_CTRL, 32'hF);
      wait_st(2'h1, 20, "idle");
      repeat (3) @(posedge core_clk);
      chk("ao supply", 32'h1, {31'h0, sup[SUP_AO]});
      chk("app switches", 32'h3, {30'h0, sw});
      mv <= 16'h1F40;
      wait_st(2'h2, 10, "low entry");
      repeat (2) @(posedge core_clk);
      chk("low switches", 32'h0, {30'h0, sw});
      rd(ADDR_STATUS, 32'h9);
      button <= 1'b1;
      hold_st(2'h2, 20, "low ignores wake");
      button <= 1'b0;
      mv <= 16'h2328;
      hold_st(2'h2, 20, "low band");
      mv <= 16'h251C;
      wait_st(2'h1, 10, "low exit");
      $display("low test done");
      wr(ADDR_CTRL, 32'h8);
      wr(ADDR_ARM, 32'h2);
      di[1] <= ~di[1];
      wait_st(2'h0, 10, "armed wake");
      p0 = pulses;
      di[1] <= ~di[1];
      repeat (8) @(posedge core_clk);
      chk("wake signal", 32'h1, 32'(pulses - p0));
      rd(ADDR_WAKE_FLAG, 32'h2);
      wr(ADDR_CTRL, 32'h9);
      hold_st(2'h0, 20, "flag blocks idle");
      wr(ADDR_WAKE_FLAG, 32'h2);
      wait_st(2'h1, 20, "idle after clear");
      $display("armed test done");
      summarize();
   end
endmodule
